// File: bench/pieb_bank_bench.sv
// self-checking bench for the peripheral interrupt enable and flag bank
`default_nettype none

module pieb_bank_bench
  import pieb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // signals
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, core_irq_req, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [5:0] ev_req;
  logic t1_evt, t2_evt, cap_evt, cmp_evt, sync_evt, conv_evt, err;
  pieb_ccp_mode_t ccp_mode;
  int mismatches, cmp_count;
  int waits;
  logic [7:0] exp_tab [6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h40};

  pieb_bank dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conversion_done_evt(conv_evt), .sync_serial_done_evt(sync_evt),
    .capcomp_one_capture_evt(cap_evt), .capcomp_one_compare_evt(cmp_evt),
    .capcomp_one_mode(ccp_mode), .timer_two_match_evt(t2_evt),
    .timer_one_overflow_evt(t1_evt), .core_irq_req(core_irq_req), .irq(irq));

  pieb_event_src src (.clk(clk), .arst_n(arst_n), .req(ev_req), .t1_evt(t1_evt),
    .t2_evt(t2_evt), .cap_evt(cap_evt), .cmp_evt(cmp_evt), .sync_evt(sync_evt),
    .conv_evt(conv_evt));

  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; outputs are judged at the following falling edge
  // no own limit on the wait: a slave that never answers is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    waits = n;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd, {24'h000000, exp});
  endtask

  task automatic fire(input int idx);
    @(posedge clk);
    ev_req <= 6'h01 << idx;
    @(posedge clk);
    ev_req <= 6'h00;
    @(posedge clk);
    // let the flag update settle before anyone looks at the request lines
    @(negedge clk);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rchk("flags", PIEB_OFF_FLAGS, 8'h00);
    rchk("enables", PIEB_OFF_ENABLES, 8'h00);
    rchk("ctrl", PIEB_OFF_CORE_CTRL, 8'h00);
    rchk("status", PIEB_OFF_IRQ_STATUS, 8'h00);
    rchk("mask", PIEB_OFF_IRQ_MASK, 8'h00);
  endtask

  task automatic t_regs();
    apb(1'b1, PIEB_OFF_ENABLES, 8'ha5);
    chk("wait states", waits, 32'h1);
    rchk("enables", PIEB_OFF_ENABLES, 8'ha5);
    apb(1'b1, PIEB_OFF_ENABLES, 8'h5a);
    rchk("enables", PIEB_OFF_ENABLES, 8'h5a);
    chk("slverr ok", {31'h0, err}, 32'h0);
    // a write without the low byte strobe must leave the register alone
    @(posedge clk);
    pstrb <= 4'he;
    apb(1'b1, PIEB_OFF_ENABLES, 8'hff);
    @(posedge clk);
    pstrb <= 4'hf;
    rchk("enables kept", PIEB_OFF_ENABLES, 8'h5a);
    apb(1'b1, PIEB_OFF_FLAGS, 8'hff);
    rchk("flags", PIEB_OFF_FLAGS, 8'h4f);
    apb(1'b1, PIEB_OFF_FLAGS, 8'h00);
    apb(1'b1, PIEB_OFF_ENABLES, 8'h00);
    rchk("flags", PIEB_OFF_FLAGS, 8'h00);
    // an unmapped write is refused and noted in the status register
    apb(1'b1, 12'h020, 8'hff);
    chk("slverr", {31'h0, err}, 32'h1);
    rchk("status", PIEB_OFF_IRQ_STATUS, 8'h02);
    apb(1'b1, PIEB_OFF_IRQ_STATUS, 8'h02);
    rchk("status", PIEB_OFF_IRQ_STATUS, 8'h00);
  endtask

  // enables and global gates all clear: events must still latch
  task automatic t_events();
    for (int i = 0; i < 6; i++) begin
      if (i != 2 && i != 3) begin
        fire(i);
        rchk("flag set", PIEB_OFF_FLAGS, exp_tab[i]);
        repeat (3) @(posedge clk);
        rchk("flag held", PIEB_OFF_FLAGS, exp_tab[i]);
        apb(1'b1, PIEB_OFF_FLAGS, 8'h00);
        rchk("flag clear", PIEB_OFF_FLAGS, 8'h00);
      end
    end
  endtask

  task automatic t_ccp();
    logic [7:0] e;
    for (int m = 0; m < 4; m++) begin
      for (int k = 2; k < 4; k++) begin
        @(posedge clk);
        ccp_mode <= pieb_ccp_mode_t'(m);
        fire(k);
        e = 8'h00;
        if ((m == PIEB_CCP_CAPTURE && k == 2) || (m == PIEB_CCP_COMPARE && k == 3)) begin
          e = 8'h04;
        end
        rchk("capcomp", PIEB_OFF_FLAGS, e);
        apb(1'b1, PIEB_OFF_FLAGS, 8'h00);
      end
    end
  endtask

  task automatic t_irq();
    apb(1'b1, PIEB_OFF_FLAGS, 8'h00);
    apb(1'b1, PIEB_OFF_ENABLES, 8'h01);
    fire(0);
    chk("req no gates", {31'h0, core_irq_req}, 32'h0);
    apb(1'b1, PIEB_OFF_CORE_CTRL, 8'h40);
    chk("req group only", {31'h0, core_irq_req}, 32'h0);
    apb(1'b1, PIEB_OFF_CORE_CTRL, 8'h80);
    chk("req global only", {31'h0, core_irq_req}, 32'h0);
    apb(1'b1, PIEB_OFF_CORE_CTRL, 8'hc0);
    chk("req both", {31'h0, core_irq_req}, 32'h1);
    rchk("status", PIEB_OFF_IRQ_STATUS, 8'h01);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, PIEB_OFF_IRQ_MASK, 8'h01);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, PIEB_OFF_IRQ_STATUS, 8'h01);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, PIEB_OFF_ENABLES, 8'hb0);
    chk("req no flag", {31'h0, core_irq_req}, 32'h0);
  endtask

  // a reset in mid-run must wipe what software and events left behind
  task automatic t_reset_mid();
    apb(1'b1, PIEB_OFF_ENABLES, 8'hff);
    fire(5);
    chk("req before reset", {31'h0, core_irq_req}, 32'h1);
    chk("irq before reset", {31'h0, irq}, 32'h1);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk("req in reset", {31'h0, core_irq_req}, 32'h0);
    chk("irq in reset", {31'h0, irq}, 32'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
  endtask

  // ==========================================================================
  // run control
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    {arst_n, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ev_req = 6'h00;
    ccp_mode = PIEB_CCP_CAPTURE;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_events();
    t_ccp();
    t_irq();
    t_reset_mid();
    test_done();
  end
endmodule

`default_nettype wire

// File: bench/pieb_event_src.sv
// peripheral event sources feeding the flag bank with one-cycle pulses
`default_nettype none

module pieb_event_src (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // commands from the bench: 0 t1, 1 t2, 2 capture, 3 compare, 4 sync, 5 conversion
  input wire logic [5:0] req,
  // event pulses
  output logic t1_evt,
  output logic t2_evt,
  output logic cap_evt,
  output logic cmp_evt,
  output logic sync_evt,
  output logic conv_evt
);
  // ==========================================================================
  // pulse register
  logic [5:0] pulse_r;
  logic [5:0] pulse_nxt;

  // a one-cycle command gives exactly one pulse, like the real peripherals
  always_comb begin
    pulse_nxt = req;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_r <= 6'h00;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  assign {conv_evt, sync_evt, cmp_evt, cap_evt, t2_evt, t1_evt} = pulse_r;
endmodule

`default_nettype wire

// File: hdl/pieb_bank.sv
// peripheral interrupt enable and flag bank with apb register access
//
// Local design decision: the APB register port.
`default_nettype none

module pieb_bank
  import pieb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral events, one-cycle pulses on clk, and the capture/compare unit mode
  input wire logic conversion_done_evt,
  input wire logic sync_serial_done_evt,
  input wire logic capcomp_one_capture_evt,
  input wire logic capcomp_one_compare_evt,
  input wire pieb_ccp_mode_t capcomp_one_mode,
  input wire logic timer_two_match_evt,
  input wire logic timer_one_overflow_evt,
  // requests
  output logic core_irq_req,
  output logic irq
);

  // ==========================================================================
  // bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic addr_hit;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  // writes carry data in the low byte lane only
  assign wr_acc = access_ph && pwrite && pstrb[0];

  always_comb begin
    case (paddr)
      PIEB_OFF_FLAGS, PIEB_OFF_ENABLES, PIEB_OFF_CORE_CTRL,
      PIEB_OFF_IRQ_STATUS, PIEB_OFF_IRQ_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  logic wr_flags;
  logic wr_enables;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  assign wr_flags = wr_acc && (paddr == PIEB_OFF_FLAGS);
  assign wr_enables = wr_acc && (paddr == PIEB_OFF_ENABLES);
  assign wr_ctrl = wr_acc && (paddr == PIEB_OFF_CORE_CTRL);
  assign wr_stat = wr_acc && (paddr == PIEB_OFF_IRQ_STATUS);
  assign wr_mask = wr_acc && (paddr == PIEB_OFF_IRQ_MASK);

  // ==========================================================================
  // event sources
  logic capcomp_set;
  logic [7:0] flag_set;

  always_comb begin
    case (capcomp_one_mode)
      PIEB_CCP_CAPTURE: capcomp_set = capcomp_one_capture_evt;
      PIEB_CCP_COMPARE: capcomp_set = capcomp_one_compare_evt;
      PIEB_CCP_PWM: capcomp_set = 1'b0;
      default: capcomp_set = 1'b0;
    endcase
  end

  // enables play no part here, so flags latch even when masked
  always_comb begin
    flag_set = 8'h00;
    flag_set[PIEB_BIT_CONVERSION] = conversion_done_evt;
    flag_set[PIEB_BIT_SYNC_SERIAL] = sync_serial_done_evt;
    flag_set[PIEB_BIT_CAPCOMP_ONE] = capcomp_set;
    flag_set[PIEB_BIT_TIMER_TWO] = timer_two_match_evt;
    flag_set[PIEB_BIT_TIMER_ONE] = timer_one_overflow_evt;
  end

  // ==========================================================================
  // flag register
  logic [7:0] flags_q;

  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (PIEB_FLAGS_IMPL[i]) begin : g_impl
      pieb_flag_cell u_cell (
        .clk(clk),
        .arst_n(arst_n),
        .set(flag_set[i]),
        .wr(wr_flags),
        .wval(pwdata[i]),
        .q(flags_q[i])
      );
    end else begin : g_none
      assign flags_q[i] = 1'b0;
    end
  end

  // ==========================================================================
  // enable, core control and mask registers
  logic [7:0] enables_r;
  logic [7:0] enables_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;

  always_comb begin
    enables_nxt = enables_r;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    if (wr_enables) begin
      enables_nxt = pwdata[7:0];
    end
    if (wr_ctrl) begin
      ctrl_nxt = pwdata[7:0] & PIEB_CTRL_IMPL;
    end
    if (wr_mask) begin
      mask_nxt = pwdata[7:0] & PIEB_STAT_IMPL;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enables_r <= PIEB_ENABLES_RST;
      ctrl_r <= PIEB_CTRL_RST;
      mask_r <= PIEB_MASK_RST;
    end else begin
      enables_r <= enables_nxt;
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ==========================================================================
  // core request
  logic pending;

  assign pending = |(flags_q & enables_r);
  // both enables must be set; either one alone blocks
  assign core_irq_req = pending && ctrl_r[PIEB_BIT_GROUP_EN]
                        && ctrl_r[PIEB_BIT_GLOBAL_EN];

  // ==========================================================================
  // own interrupt status, write one to clear, set wins
  logic req_d_r;
  logic req_d_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] stat_set;

  always_comb begin
    stat_set = 8'h00;
    stat_set[PIEB_BIT_STAT_REQ] = core_irq_req && !req_d_r;
    stat_set[PIEB_BIT_STAT_BUSERR] = access_ph && !addr_hit;
    req_d_nxt = core_irq_req;
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~pwdata[7:0];
    end
    stat_nxt = (stat_nxt | stat_set) & PIEB_STAT_IMPL;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_d_r <= 1'b0;
      stat_r <= PIEB_STAT_RST;
    end else begin
      req_d_r <= req_d_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign irq = |(stat_r & mask_r);

  // ==========================================================================
  // apb read path, data captured in the setup cycle
  logic [7:0] rd_byte;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  always_comb begin
    case (paddr)
      PIEB_OFF_FLAGS: rd_byte = flags_q & PIEB_FLAGS_IMPL;
      PIEB_OFF_ENABLES: rd_byte = enables_r;
      PIEB_OFF_CORE_CTRL: rd_byte = ctrl_r;
      PIEB_OFF_IRQ_STATUS: rd_byte = stat_r;
      PIEB_OFF_IRQ_MASK: rd_byte = mask_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // one access costs no wait state; the trade is that a flag set during
  // the access phase shows up on the next read, not this one
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup_ph) begin
      prdata_nxt = {24'h000000, rd_byte};
      pslverr_nxt = !addr_hit;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = 1'b1;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_flag_write;
    psel && penable && pwrite && pstrb[0] && (paddr == PIEB_OFF_FLAGS);
  endsequence

  sequence s_enable_write;
    psel && penable && pwrite && pstrb[0] && (paddr == PIEB_OFF_ENABLES);
  endsequence

  sequence s_flag_read;
    psel && !penable && !pwrite && (paddr == PIEB_OFF_FLAGS) ##1 psel && penable;
  endsequence

  chk_enable_store: assert property (
    s_enable_write |=> (enables_r == $past(pwdata[7:0])))
    else $error("enable register did not take the written byte");

  chk_flag_unmasked: assert property (
    (conversion_done_evt && !enables_r[PIEB_BIT_CONVERSION] && !ctrl_r[PIEB_BIT_GLOBAL_EN])
    |=> flags_q[PIEB_BIT_CONVERSION])
    else $error("flag not set while disabled");

  chk_unimpl_zero: assert property (
    s_flag_read |-> (prdata[7] == 1'b0) && (prdata[5:4] == 2'b00))
    else $error("unimplemented flag bits read nonzero");

  chk_conv_hold: assert property (
    flags_q[PIEB_BIT_CONVERSION] && !(wr_flags && !pwdata[PIEB_BIT_CONVERSION])
    |=> flags_q[PIEB_BIT_CONVERSION])
    else $error("conversion flag dropped without a clearing write");

  chk_sync_set: assert property (
    sync_serial_done_evt |=> flags_q[PIEB_BIT_SYNC_SERIAL])
    else $error("sync serial flag not set");

  chk_capture_set: assert property (
    (capcomp_one_mode == PIEB_CCP_CAPTURE) && capcomp_one_capture_evt
    |=> flags_q[PIEB_BIT_CAPCOMP_ONE])
    else $error("capture did not set the capture flag");

  chk_pwm_quiet: assert property (
    (capcomp_one_mode == PIEB_CCP_PWM) && !wr_flags && !flags_q[PIEB_BIT_CAPCOMP_ONE]
    |=> !flags_q[PIEB_BIT_CAPCOMP_ONE])
    else $error("capture flag set in pulse-width mode");

  chk_compare_set: assert property (
    (capcomp_one_mode == PIEB_CCP_COMPARE) && capcomp_one_compare_evt
    |=> flags_q[PIEB_BIT_CAPCOMP_ONE])
    else $error("compare match did not set the flag");

  chk_timer_two: assert property (
    timer_two_match_evt ##1 !wr_flags [*3] |-> flags_q[PIEB_BIT_TIMER_TWO])
    else $error("timer-2 flag lost before a clearing write");

  chk_timer_one: assert property (
    s_flag_write and (pwdata[PIEB_BIT_TIMER_ONE] == 1'b0) && !timer_one_overflow_evt
    |=> !flags_q[PIEB_BIT_TIMER_ONE] or timer_one_overflow_evt)
    else $error("timer-1 flag did not clear on write of zero");

  chk_group_gate: assert property (
    !ctrl_r[PIEB_BIT_GROUP_EN] |-> !core_irq_req)
    else $error("request passed with group enable clear");

  chk_global_gate: assert property (
    !ctrl_r[PIEB_BIT_GLOBAL_EN] |-> !core_irq_req)
    else $error("request passed with global enable clear");

  chk_req_rise: assert property (
    $rose(core_irq_req) |-> (|(flags_q & enables_r)) ##1 stat_r[PIEB_BIT_STAT_REQ])
    else $error("request rose without a pending enabled flag");

  chk_reset_clear: assert property (
    !$past(arst_n) |-> (flags_q == 8'h00) && (enables_r == 8'h00) && !core_irq_req)
    else $error("registers not clear after reset");

endmodule

`default_nettype wire

// File: hdl/pieb_flag_cell.sv
// one sticky event flag: hardware set, software write
`default_nettype none

module pieb_flag_cell (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // set and write
  input wire logic set,
  input wire logic wr,
  input wire logic wval,
  // state
  output logic q
);

  // ==========================================================================
  // next value
  logic q_r;
  logic q_nxt;

  // set beats a write in the same cycle so no event is lost
  always_comb begin
    q_nxt = q_r;
    if (wr) begin
      q_nxt = wval;
    end
    if (set) begin
      q_nxt = 1'b1;
    end
  end

  // ==========================================================================
  // register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// File: include/pieb_pkg.sv
// constants and types shared by the peripheral interrupt enable and flag bank
`default_nettype none

package pieb_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] PIEB_OFF_FLAGS = 12'h00c;
  localparam logic [11:0] PIEB_OFF_ENABLES = 12'h08c;
  localparam logic [11:0] PIEB_OFF_CORE_CTRL = 12'h010;
  localparam logic [11:0] PIEB_OFF_IRQ_STATUS = 12'h014;
  localparam logic [11:0] PIEB_OFF_IRQ_MASK = 12'h018;

  // ==========================================================================
  // field positions of the flag and enable bytes
  localparam int PIEB_BIT_PARALLEL = 7;
  localparam int PIEB_BIT_CONVERSION = 6;
  localparam int PIEB_BIT_SERIAL_RX = 5;
  localparam int PIEB_BIT_SERIAL_TX = 4;
  localparam int PIEB_BIT_SYNC_SERIAL = 3;
  localparam int PIEB_BIT_CAPCOMP_ONE = 2;
  localparam int PIEB_BIT_TIMER_TWO = 1;
  localparam int PIEB_BIT_TIMER_ONE = 0;

  // core control and own interrupt status fields
  localparam int PIEB_BIT_GLOBAL_EN = 7;
  localparam int PIEB_BIT_GROUP_EN = 6;
  localparam int PIEB_BIT_STAT_REQ = 0;
  localparam int PIEB_BIT_STAT_BUSERR = 1;

  // ==========================================================================
  // implemented bits and reset values
  localparam logic [7:0] PIEB_FLAGS_IMPL = 8'h4f;
  localparam logic [7:0] PIEB_FLAGS_RST = 8'h00;
  localparam logic [7:0] PIEB_ENABLES_RST = 8'h00;
  localparam logic [7:0] PIEB_CTRL_IMPL = 8'hc0;
  localparam logic [7:0] PIEB_CTRL_RST = 8'h00;
  localparam logic [7:0] PIEB_STAT_IMPL = 8'h03;
  localparam logic [7:0] PIEB_STAT_RST = 8'h00;
  localparam logic [7:0] PIEB_MASK_RST = 8'h00;

  // ==========================================================================
  // capture/compare unit operating mode
  typedef enum logic [1:0] {
    PIEB_CCP_OFF,
    PIEB_CCP_CAPTURE,
    PIEB_CCP_COMPARE,
    PIEB_CCP_PWM
  } pieb_ccp_mode_t;

endpackage

`default_nettype wire
